// ==== inc/xor_dir_pkg.sv ====
// Constants for the XOR and direction-load execution block.
// Assumes an 8-bit accumulator, 7-bit file address and one-cycle execution.
package xor_dir_pkg;
  localparam int DATA_W = 8;
  localparam int FILE_AW = 7;
  localparam logic [2:0] SEL_PORT_A = 3'h5;
  localparam logic [2:0] SEL_PORT_B = 3'h6;
  localparam logic [2:0] SEL_PORT_C = 3'h7;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_LOAD_DIR = 2'b01,
    OP_XOR_LIT = 2'b10,
    OP_XOR_FILE = 2'b11
  } op_t;
endpackage : xor_dir_pkg

// ==== core/xor_unit.sv ====
// Combinational XOR with zero detect.
// Assumes operands are stable during the cycle in which the result is used.
`timescale 1ns/1ps
module xor_unit
  import xor_dir_pkg::*;
(
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  output logic [7:0] result_out,
  output logic zero_out
);
  always_comb begin
    result_out = a_in ^ b_in;
    zero_out = (result_out == 8'h00);
  end
endmodule : xor_unit

// ==== core/xor_dir_exec.sv ====
// Execution of direction-load, literal XOR and file XOR instructions.
// Assumes the decoder presents one op per cycle with its operands valid alongside.
//
// Overview of operation
// (RL1) Direction load copies accumulator to port A, B or C direction by operand 5/6/7.
// (RL2) Direction load moves accumulator unchanged and leaves all status flags alone.
// (RL3) Literal XOR puts accumulator XOR 8-bit immediate in accumulator; only zero flag.
// (RL4) File XOR combines accumulator with file location 0..127; only zero flag changes.
// (RL5) File XOR destination bit 0 writes accumulator, bit 1 writes file location.
// (RL6) Zero flag set when XOR result is all zeros, cleared otherwise.
`timescale 1ns/1ps
module xor_dir_exec
  import xor_dir_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [1:0] op_in,
  input wire logic [2:0] dir_sel_in,
  input wire logic [7:0] literal_in,
  input wire logic [6:0] file_addr_in,
  input wire logic dest_in,
  input wire logic [7:0] file_rdata_in,
  input wire logic carry_in,
  input wire logic digit_carry_in,
  output logic [7:0] acc_out,
  output logic zero_out,
  output logic carry_out,
  output logic digit_carry_out,
  output logic [7:0] port_a_direction_out,
  output logic [7:0] port_b_direction_out,
  output logic [7:0] port_c_direction_out,
  output logic file_we_out,
  output logic [6:0] file_waddr_out,
  output logic [7:0] file_wdata_out
);
  op_t op;
  logic [7:0] acc_q, acc_d;
  logic zero_q, zero_d;
  logic carry_q, carry_d, dc_q, dc_d;
  logic [7:0] dir_a_q, dir_a_d, dir_b_q, dir_b_d, dir_c_q, dir_c_d;
  logic we_q, we_d;
  logic [6:0] waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [7:0] operand_b, xor_res;
  logic xor_zero;

  assign op = op_t'(op_in);
  assign operand_b = (op == OP_XOR_LIT) ? literal_in : file_rdata_in;

  xor_unit xor_unit_i (
    .a_in(acc_q),
    .b_in(operand_b),
    .result_out(xor_res),
    .zero_out(xor_zero)
  );

  always_comb begin
    acc_d = acc_q;
    zero_d = zero_q;
    // Carry flags follow the core's ALU only while none of this block's ops runs
    carry_d = carry_in;
    dc_d = digit_carry_in;
    dir_a_d = dir_a_q;
    dir_b_d = dir_b_q;
    dir_c_d = dir_c_q;
    we_d = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    case (op)
      OP_LOAD_DIR: begin
        // (RL1) Select direction register
        if (dir_sel_in == SEL_PORT_A) begin
          dir_a_d = acc_q;
        end else if (dir_sel_in == SEL_PORT_B) begin
          dir_b_d = acc_q;
        end else if (dir_sel_in == SEL_PORT_C) begin
          dir_c_d = acc_q;
        end
        // (RL2) Flags held unchanged
        carry_d = carry_q;
        dc_d = dc_q;
      end
      OP_XOR_LIT: begin
        // (RL3) Literal result to accumulator
        acc_d = xor_res;
        // (RL6) Zero from result
        zero_d = xor_zero;
        // (RL3) Carry flags held
        carry_d = carry_q;
        dc_d = dc_q;
      end
      OP_XOR_FILE: begin
        // (RL4) File XOR, zero only
        zero_d = xor_zero;
        carry_d = carry_q;
        dc_d = dc_q;
        // (RL5) Destination select
        if (dest_in == DEST_FILE) begin
          we_d = 1'b1;
          waddr_d = file_addr_in;
          wdata_d = xor_res;
        end else begin
          acc_d = xor_res;
        end
      end
      default: begin
        acc_d = acc_q;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_q <= ACC_RESET;
      zero_q <= ZERO_RESET;
      carry_q <= 1'b0;
      dc_q <= 1'b0;
      dir_a_q <= DIR_RESET;
      dir_b_q <= DIR_RESET;
      dir_c_q <= DIR_RESET;
      we_q <= 1'b0;
      waddr_q <= 7'h00;
      wdata_q <= 8'h00;
    end else begin
      acc_q <= acc_d;
      zero_q <= zero_d;
      carry_q <= carry_d;
      dc_q <= dc_d;
      dir_a_q <= dir_a_d;
      dir_b_q <= dir_b_d;
      dir_c_q <= dir_c_d;
      we_q <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
    end
  end

  assign acc_out = acc_q;
  assign zero_out = zero_q;
  assign carry_out = carry_q;
  assign digit_carry_out = dc_q;
  assign port_a_direction_out = dir_a_q;
  assign port_b_direction_out = dir_b_q;
  assign port_c_direction_out = dir_c_q;
  assign file_we_out = we_q;
  assign file_waddr_out = waddr_q;
  assign file_wdata_out = wdata_q;

  sequence s_load_a;
    op_in == OP_LOAD_DIR && dir_sel_in == SEL_PORT_A;
  endsequence
  property p_load_a;
    @(posedge clock_in) disable iff (!rst_n_in)
      s_load_a |=> port_a_direction_out == $past(acc_out);
  endproperty
  a_load_a: assert property (p_load_a) else $error("port A direction not loaded"); // RL1
  property p_load_b;
    @(posedge clock_in) disable iff (!rst_n_in)
      (op_in == OP_LOAD_DIR && dir_sel_in == SEL_PORT_B)
      |=> port_b_direction_out == $past(acc_out) && $stable(port_a_direction_out);
  endproperty
  a_load_b: assert property (p_load_b) else $error("port B direction wrong"); // RL1
  property p_load_flags;
    @(posedge clock_in) disable iff (!rst_n_in)
      op_in == OP_LOAD_DIR |=> $stable(zero_out) && $stable(acc_out) && $stable(carry_out)
          && $stable(digit_carry_out);
  endproperty
  a_load_flags: assert property (p_load_flags) else $error("direction load changed state"); // RL2
  property p_xor_lit;
    @(posedge clock_in) disable iff (!rst_n_in)
      op_in == OP_XOR_LIT |=> acc_out == ($past(acc_out) ^ $past(literal_in));
  endproperty
  a_xor_lit: assert property (p_xor_lit) else $error("literal xor result wrong"); // RL3
  property p_xor_file_acc;
    @(posedge clock_in) disable iff (!rst_n_in)
      (op_in == OP_XOR_FILE && dest_in == DEST_ACC)
      |=> acc_out == ($past(acc_out) ^ $past(file_rdata_in)) && !file_we_out;
  endproperty
  a_xor_file_acc: assert property (p_xor_file_acc) else $error("file xor to acc wrong"); // RL4
  property p_xor_file_wr;
    @(posedge clock_in) disable iff (!rst_n_in)
      (op_in == OP_XOR_FILE && dest_in == DEST_FILE)
      |=> file_we_out && file_waddr_out == $past(file_addr_in) && $stable(acc_out)
          && file_wdata_out == ($past(acc_out) ^ $past(file_rdata_in));
  endproperty
  a_xor_file_wr: assert property (p_xor_file_wr) else $error("file writeback wrong"); // RL5
  property p_zero;
    @(posedge clock_in) disable iff (!rst_n_in)
      (op_in == OP_XOR_LIT || op_in == OP_XOR_FILE)
      |=> zero_out == (($past(acc_out) ^ $past(operand_b)) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // RL6
  property p_we_pulse;
    @(posedge clock_in) disable iff (!rst_n_in)
      file_we_out |-> $past(op_in) == OP_XOR_FILE && $past(dest_in) == DEST_FILE;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("spurious file write"); // RL5
  sequence s_xor_any;
    op_in == OP_XOR_LIT || op_in == OP_XOR_FILE;
  endsequence
  // The ALU carry inputs must be ignored while an XOR executes
  property p_xor_flags;
    @(posedge clock_in) disable iff (!rst_n_in)
      s_xor_any |=> $stable(carry_out) && $stable(digit_carry_out);
  endproperty
  a_xor_flags: assert property (p_xor_flags) else $error("xor changed carry flags"); // RL3
  property p_xor_file_flags;
    @(posedge clock_in) disable iff (!rst_n_in)
      op_in == OP_XOR_FILE |=> $stable(carry_out) && $stable(digit_carry_out);
  endproperty
  a_xor_file_flags: assert property (p_xor_file_flags) else $error("file xor moved carry"); // RL4
  sequence s_load_c;
    op_in == OP_LOAD_DIR && dir_sel_in == SEL_PORT_C;
  endsequence
  property p_load_c;
    @(posedge clock_in) disable iff (!rst_n_in)
      s_load_c |=> port_c_direction_out == $past(acc_out)
          && $stable(port_a_direction_out) && $stable(port_b_direction_out);
  endproperty
  a_load_c: assert property (p_load_c) else $error("port C direction wrong"); // RL1
  sequence s_load_refused;
    op_in == OP_LOAD_DIR && dir_sel_in != SEL_PORT_A && dir_sel_in != SEL_PORT_B
        && dir_sel_in != SEL_PORT_C;
  endsequence
  // A select outside 5..7 must not touch any direction register
  property p_load_refused;
    @(posedge clock_in) disable iff (!rst_n_in)
      s_load_refused |=> $stable(port_a_direction_out) && $stable(port_b_direction_out)
          && $stable(port_c_direction_out);
  endproperty
  a_load_refused: assert property (p_load_refused) else $error("bad select loaded"); // RL1
  property p_dir_hold;
    @(posedge clock_in) disable iff (!rst_n_in)
      op_in != OP_LOAD_DIR |=> $stable(port_a_direction_out) && $stable(port_b_direction_out)
          && $stable(port_c_direction_out);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved without load"); // RL1
endmodule : xor_dir_exec

// ==== bench/file_mem_model.sv ====
// Data memory model on the far side of the execution block.
// Assumes a combinational read port and writes taken on the rising edge.
`timescale 1ns/1ps
module file_mem_model (
  input wire logic clock_in,
  input wire logic [6:0] raddr_in,
  input wire logic we_in,
  input wire logic [6:0] waddr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [128];
  // Contents follow the address so the bench can reckon them
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = {i[6:0], 1'b1};
    end
  end
  assign rdata_out = mem[raddr_in];
  always @(posedge clock_in) begin
    if (we_in === 1'b1) begin
      mem[waddr_in] <= wdata_in;
    end
  end
endmodule : file_mem_model

// ==== bench/tb_xor_dir_exec.sv ====
// Self-checking bench for the XOR and direction-load block.
// Assumes one op per cycle, results visible 1 ns after the edge.
`timescale 1ns/1ps
module tb_xor_dir_exec
  import xor_dir_pkg::*;
;
  logic clock_in = 0;
  logic rst_n_in = 0;
  logic [1:0] op = 0;
  logic [7:0] lit = 0;
  logic dest = 0;
  logic cy = 0;
  logic [7:0] acc, rdata, pa, pb, pc, wdata;
  logic z, c, dc, we;
  logic [6:0] waddr;
  int n_fail = 0;
  int tests_run = 0;
  initial begin
    forever #12.5 clock_in = ~clock_in;
  end
  xor_dir_exec xor_dir_exec_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .op_in(op),
    .dir_sel_in(lit[2:0]), .literal_in(lit), .file_addr_in(lit[6:0]), .dest_in(dest),
    .file_rdata_in(rdata), .carry_in(cy), .digit_carry_in(cy), .acc_out(acc),
    .zero_out(z), .carry_out(c), .digit_carry_out(dc), .port_a_direction_out(pa),
    .port_b_direction_out(pb), .port_c_direction_out(pc), .file_we_out(we),
    .file_waddr_out(waddr), .file_wdata_out(wdata));
  file_mem_model file_mem_model_i (.clock_in(clock_in), .raddr_in(lit[6:0]),
    .we_in(we), .waddr_in(waddr), .wdata_in(wdata), .rdata_out(rdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic run_op(input logic [1:0] o, input logic [7:0] v, input logic d);
    // Op stays up; the next call replaces it before the following edge
    op = o;
    lit = v;
    dest = d;
    @(posedge clock_in);
    #1;
  endtask : run_op
  task automatic xor_literal_test();
    run_op(OP_XOR_LIT, 8'h0f, 1'b0);
    chk(acc, 8'h0f);
    chk({7'h0, z}, 8'h00);
    run_op(OP_XOR_LIT, 8'h0f, 1'b0);
    chk(acc, 8'h00);
    chk({7'h0, z}, 8'h01);
  endtask : xor_literal_test
  task automatic load_direction_test();
    run_op(OP_XOR_LIT, 8'ha5, 1'b0);
    // Carry presented high only with the load, so a pass-through would show
    cy = 1'b1;
    run_op(OP_LOAD_DIR, 8'h05, 1'b0);
    cy = 1'b0;
    chk(pa, 8'ha5);
    chk({6'h0, c, dc}, 8'h00);
    chk(acc, 8'ha5);
    run_op(OP_XOR_LIT, 8'h0f, 1'b0);
    run_op(OP_LOAD_DIR, 8'h06, 1'b0);
    chk(pb, 8'haa);
    run_op(OP_LOAD_DIR, 8'h07, 1'b0);
    chk(pc, 8'haa);
    run_op(OP_XOR_LIT, 8'haa, 1'b0);
    run_op(OP_LOAD_DIR, 8'h04, 1'b0);
    chk(pa, 8'ha5);
    chk({7'h0, z}, 8'h01);
  endtask : load_direction_test
  task automatic xor_file_test();
    run_op(OP_XOR_LIT, 8'ha5, 1'b0);
    run_op(OP_XOR_FILE, 8'h7f, 1'b1);
    chk({we, waddr}, 8'hff);
    chk(wdata, 8'h5a);
    chk(acc, 8'ha5);
    // Idle cycle lets the write-back land before the location is read again
    run_op(OP_NONE, 8'h7f, 1'b0);
    chk({7'h0, we}, 8'h00);
    run_op(OP_XOR_FILE, 8'h7f, 1'b0);
    chk({7'h0, we}, 8'h00);
    chk(acc, 8'hff);
    run_op(OP_XOR_LIT, 8'hfe, 1'b0);
    run_op(OP_XOR_FILE, 8'h00, 1'b0);
    chk(acc, 8'h00);
    chk({7'h0, z}, 8'h01);
  endtask : xor_file_test
  task automatic check_reset();
    chk(acc, ACC_RESET);
    chk(pa, DIR_RESET);
    chk(pb, DIR_RESET);
    chk(pc, DIR_RESET);
    chk({5'h0, z, c, dc}, {5'h0, ZERO_RESET, 2'h0});
    chk({we, waddr}, 8'h00);
    chk(wdata, 8'h00);
  endtask : check_reset
  task automatic carry_hold_test();
    cy = 1'b1;
    run_op(OP_NONE, 8'h00, 1'b0);
    chk({6'h0, c, dc}, 8'h03);
    // Inputs drop low so a pass-through during the XOR ops would show
    cy = 1'b0;
    run_op(OP_XOR_LIT, 8'h00, 1'b0);
    chk({6'h0, c, dc}, 8'h03);
    run_op(OP_XOR_FILE, 8'h10, 1'b0);
    chk({6'h0, c, dc}, 8'h03);
    chk(acc, 8'h21);
    chk({7'h0, z}, 8'h00);
  endtask : carry_hold_test
  task automatic reset_test();
    rst_n_in = 1'b0;
    op = OP_NONE;
    repeat (2) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    check_reset();
    run_op(OP_XOR_LIT, 8'h3c, 1'b0);
    chk(acc, 8'h3c);
    chk({7'h0, z}, 8'h00);
  endtask : reset_test
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (2000) @(posedge clock_in);
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    check_reset();
    xor_literal_test();
    load_direction_test();
    xor_file_test();
    carry_hold_test();
    reset_test();
    report_and_stop();
  end
endmodule : tb_xor_dir_exec
